// [src/irsc_pkg.sv]
// ---------------------------------------------------------------------------
// Functional notes
// - three lines: clock, write data, read
// - decode special, write, read, extended read frames
// - sample write data on serial clock rise
// - act only on own or broadcast address
// - sync 0 then 1, direction, index, address
// - all fields travel least significant bit first
// - special reset code restores all register defaults
// - writes use clock and write data only
// - index 1111 escapes to extended commands
// - four-bit register index in the header
// - mode register: 00 SIR, 05 VFIR
// - follow framing of every frame, even ignored
// - support special, basic write, basic read only
// - write: header, separator, eight data, two stops
// - thirty low clocks reset state and registers
// - direction 1 write or reset, 0 read
// - no response phase for broadcast reads
// ---------------------------------------------------------------------------
package irsc_pkg;

  // -------------------------------------------------------------------------
  // frame field values
  // -------------------------------------------------------------------------
  localparam logic       IRSC_SYNC_FIRST = 1'b0;
  localparam logic       IRSC_SYNC_SECOND = 1'b1;
  localparam logic       IRSC_DIR_WRITE  = 1'b1;
  localparam logic [2:0] IRSC_OWN_ADDR   = 3'h2;
  localparam logic [2:0] IRSC_BCAST_ADDR = 3'h7;
  localparam logic [3:0] IRSC_IDX_COMMON = 4'h0;
  localparam logic [3:0] IRSC_IDX_RXMODE = 4'h1;
  localparam logic [3:0] IRSC_IDX_LED    = 4'h2;
  localparam logic [3:0] IRSC_IDX_RESET  = 4'hD;
  localparam logic [3:0] IRSC_IDX_ESCAPE = 4'hF;
  localparam logic [7:0] IRSC_RX_SIR     = 8'h00;
  localparam logic [7:0] IRSC_RX_VFIR    = 8'h05;

  // -------------------------------------------------------------------------
  // bit counts per frame section, as last count value
  // -------------------------------------------------------------------------
  localparam logic [3:0] IRSC_HDR_LAST  = 4'h7;
  localparam logic [3:0] IRSC_DATA_LAST = 4'h7;
  localparam logic [3:0] IRSC_STOP_LAST = 4'h1;
  localparam logic [3:0] IRSC_XGAP_LAST = 4'h3;
  localparam logic [3:0] IRSC_RESP_LAST = 4'h7;
  localparam logic [4:0] IRSC_IDLE_LOW  = 5'h1E;

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef enum logic [3:0] {
    IRSC_S_HUNT0 = 4'h0,
    IRSC_S_HUNT1 = 4'h1,
    IRSC_S_HDR   = 4'h3,
    IRSC_S_SEP   = 4'h2,
    IRSC_S_DATA  = 4'h6,
    IRSC_S_STOP  = 4'h7,
    IRSC_S_RDY   = 4'hB,
    IRSC_S_RESP  = 4'hA,
    IRSC_S_XIDX  = 4'h9,
    IRSC_S_XGAP  = 4'h8
  } irsc_state_t;

  typedef struct packed {
    logic [7:0] common;
    logic [7:0] rx_mode;
    logic [7:0] led;
  } irsc_ctrl_t;

  // register defaults
  localparam logic [7:0] IRSC_COMMON_RST = 8'h00;
  localparam logic [7:0] IRSC_LED_RST    = 8'h00;
  localparam irsc_ctrl_t IRSC_CTRL_RST   = '{
    common:  IRSC_COMMON_RST,
    rx_mode: IRSC_RX_SIR,
    led:     IRSC_LED_RST
  };

endpackage : irsc_pkg

// [src/irsc_sync2.sv]
`timescale 1ns/10ps
// two-stage level synchroniser; first stage feeds only the second
module irsc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  // ---------------------------------------------------------------------------
  // two flops, cleared by reset
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= d_i;
      hold_r <= meta_r;
    end
  end

  assign q_o = hold_r;

endmodule : irsc_sync2

// [src/irsc_idle_det.sv]
`timescale 1ns/10ps
// counts serial clocks with write data low
module irsc_idle_det
  import irsc_pkg::*;
(
  // link clock and reset
  input  wire logic sclk_i,
  input  wire logic rst_b_i,
  // sampled write data
  input  wire logic wd_i,
  output logic      idle_o
);

  logic [4:0] low_cnt_r;

  // saturating count so the reset fires once per long low stretch
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_cnt_r <= '0;
    end else if (wd_i) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != IRSC_IDLE_LOW) begin
      low_cnt_r <= low_cnt_r + 5'h1;
    end
  end

  // thirtieth consecutive low edge
  assign idle_o = !wd_i && (low_cnt_r == IRSC_IDLE_LOW - 5'h1);

endmodule : irsc_idle_det

// [src/irsc_top.sv]
`timescale 1ns/10ps
module irsc_top
  import irsc_pkg::*;
(
  // system clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // serial control link
  input  wire logic              sclk_i,
  input  wire logic              write_data_pin_i,
  output logic                   read_data_o,
  output logic                   read_data_oe_o,
  // receiver signal sharing the read line
  input  wire logic              rx_data_i,
  input  wire logic              rx_oe_i,
  // control outputs
  output irsc_pkg::irsc_ctrl_t   ctrl_o,
  output logic                   rx_sir_o,
  output logic                   rx_vfir_o,
  output logic                   ctrl_upd_o
);
  import irsc_pkg::*;

  // ---------------------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------------------
  function automatic logic addr_hit(input logic [2:0] a);
    return (a == IRSC_OWN_ADDR) || (a == IRSC_BCAST_ADDR);
  endfunction : addr_hit

  function automatic logic idx_known(input logic [3:0] i);
    return (i == IRSC_IDX_COMMON) || (i == IRSC_IDX_RXMODE) ||
           (i == IRSC_IDX_LED);
  endfunction : idx_known

  function automatic logic [7:0] reg_pick(input irsc_ctrl_t c,
                                          input logic [3:0] i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      IRSC_IDX_COMMON: v = c.common;
      IRSC_IDX_RXMODE: v = c.rx_mode;
      IRSC_IDX_LED:    v = c.led;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction : reg_pick

  // ---------------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------------
  logic rst_sync_b;

  irsc_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (1'b1),
    .q_o     (rst_sync_b)
  );

  // ---------------------------------------------------------------------------
  // link domain: frame decoder
  // ---------------------------------------------------------------------------
  irsc_state_t st_r;
  logic [3:0]  cnt_r;
  logic [7:0]  hdr_r;
  logic [7:0]  dat_r;
  logic [7:0]  sh_r;
  logic        resp_en_r;
  logic        stop_ok_r;
  irsc_ctrl_t  regs_r;
  logic        tog_r;
  logic        wd;
  logic        idle;
  logic [7:0]  hdr_nxt;
  logic [7:0]  dat_nxt;
  logic        dir;
  logic [3:0]  idx;
  logic [2:0]  addr;
  logic        frame_end;
  logic        wr_commit;
  logic        rst_cmd;

  // write data is sampled on the link clock itself, no resync needed
  assign wd      = write_data_pin_i;
  // lsb first: new bit enters at the top and walks down
  assign hdr_nxt = {wd, hdr_r[7:1]};
  assign dat_nxt = {wd, dat_r[7:1]};
  assign dir     = hdr_r[0];
  assign idx     = hdr_r[4:1];
  assign addr    = hdr_r[7:5];

  // a write or reset frame acts only when both stop bits are zero
  assign frame_end = (st_r == IRSC_S_STOP) && (cnt_r == IRSC_STOP_LAST) &&
                     stop_ok_r && !wd;
  assign rst_cmd   = frame_end && (dir == IRSC_DIR_WRITE) &&
                     (idx == IRSC_IDX_RESET) && addr_hit(addr);
  // escape and unknown indexes complete framing but write nothing
  assign wr_commit = frame_end && (dir == IRSC_DIR_WRITE) &&
                     idx_known(idx) && addr_hit(addr);

  irsc_idle_det u_idle (
    .sclk_i  (sclk_i),
    .rst_b_i (rst_sync_b),
    .wd_i    (wd),
    .idle_o  (idle)
  );

  // frame sequencer; idle reset overrides everything
  always_ff @(posedge sclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r  <= IRSC_S_HUNT0;
      cnt_r <= '0;
    end else if (idle) begin
      st_r  <= IRSC_S_HUNT0;
      cnt_r <= '0;
    end else begin
      case (st_r)
        IRSC_S_HUNT0: begin
          if (wd == IRSC_SYNC_FIRST) begin
            st_r <= IRSC_S_HUNT1;
          end
        end
        IRSC_S_HUNT1: begin
          if (wd == IRSC_SYNC_SECOND) begin
            st_r  <= IRSC_S_HDR;
            cnt_r <= '0;
          end
        end
        IRSC_S_HDR: begin
          if (cnt_r == IRSC_HDR_LAST) begin
            cnt_r <= '0;
            if (hdr_nxt[0] == IRSC_DIR_WRITE) begin
              st_r <= (hdr_nxt[4:1] == IRSC_IDX_RESET) ?
                      IRSC_S_STOP : IRSC_S_SEP;
            end else begin
              st_r <= (hdr_nxt[4:1] == IRSC_IDX_ESCAPE) ?
                      IRSC_S_XIDX : IRSC_S_RDY;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        IRSC_S_SEP: begin
          st_r  <= IRSC_S_DATA;
          cnt_r <= '0;
        end
        IRSC_S_DATA: begin
          if (cnt_r == IRSC_DATA_LAST) begin
            st_r  <= IRSC_S_STOP;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        IRSC_S_STOP: begin
          if (cnt_r == IRSC_STOP_LAST) begin
            st_r  <= IRSC_S_HUNT0;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        IRSC_S_RDY: begin
          st_r  <= IRSC_S_RESP;
          cnt_r <= '0;
        end
        IRSC_S_XIDX: begin
          if (cnt_r == IRSC_DATA_LAST) begin
            st_r  <= IRSC_S_XGAP;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        IRSC_S_XGAP: begin
          if (cnt_r == IRSC_XGAP_LAST) begin
            st_r  <= IRSC_S_RESP;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        IRSC_S_RESP: begin
          if (cnt_r == IRSC_RESP_LAST) begin
            st_r  <= IRSC_S_HUNT0;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          st_r  <= IRSC_S_HUNT0;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // header and data shifters, stop bit check
  always_ff @(posedge sclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hdr_r     <= '0;
      dat_r     <= '0;
      stop_ok_r <= 1'b0;
    end else begin
      if (st_r == IRSC_S_HDR) begin
        hdr_r <= hdr_nxt;
      end
      if (st_r == IRSC_S_DATA) begin
        dat_r <= dat_nxt;
      end
      if (st_r == IRSC_S_STOP) begin
        stop_ok_r <= (cnt_r == '0) ? !wd : (stop_ok_r && !wd);
      end
    end
  end

  // response: own address only, broadcast reads stay silent
  always_ff @(posedge sclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      resp_en_r <= 1'b0;
      sh_r      <= '0;
    end else if (idle) begin
      resp_en_r <= 1'b0;
    end else if (st_r == IRSC_S_HDR && cnt_r == IRSC_HDR_LAST) begin
      resp_en_r <= (hdr_nxt[0] != IRSC_DIR_WRITE) &&
                   (hdr_nxt[7:5] == IRSC_OWN_ADDR) &&
                   idx_known(hdr_nxt[4:1]);
    end else if (st_r == IRSC_S_RDY) begin
      sh_r <= reg_pick(regs_r, idx);
    end else if (st_r == IRSC_S_RESP) begin
      sh_r <= {1'b0, sh_r[7:1]};
      if (cnt_r == IRSC_RESP_LAST) begin
        resp_en_r <= 1'b0;
      end
    end
  end

  // register file; defaults on idle or the special reset
  always_ff @(posedge sclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      regs_r <= IRSC_CTRL_RST;
    end else if (idle || rst_cmd) begin
      regs_r <= IRSC_CTRL_RST;
    end else if (wr_commit) begin
      case (idx)
        IRSC_IDX_COMMON: regs_r.common  <= dat_r;
        IRSC_IDX_RXMODE: regs_r.rx_mode <= dat_r;
        IRSC_IDX_LED:    regs_r.led     <= dat_r;
        default:         regs_r         <= regs_r;
      endcase
    end
  end

  // change toggle; regs_r then holds for a whole frame, far longer
  // than the crossing takes
  always_ff @(posedge sclk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tog_r <= 1'b0;
    end else if (idle || rst_cmd || wr_commit) begin
      tog_r <= !tog_r;
    end
  end

  // read line: response bits, else the receiver signal
  assign read_data_oe_o = ((st_r == IRSC_S_RESP) && resp_en_r) ||
                          rx_oe_i;
  assign read_data_o    = ((st_r == IRSC_S_RESP) && resp_en_r) ?
                          sh_r[0] : rx_data_i;

  // ---------------------------------------------------------------------------
  // system domain: capture settled registers
  // ---------------------------------------------------------------------------
  logic tog_s;
  logic tog_q_r;

  irsc_sync2 #(.WIDTH(1)) u_tog_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_sync_b),
    .d_i     (tog_r),
    .q_o     (tog_s)
  );

  // copy on each toggle edge; static link clock needs no edges here
  always_ff @(posedge clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tog_q_r    <= 1'b0;
      ctrl_o     <= IRSC_CTRL_RST;
      rx_sir_o   <= 1'b1;
      rx_vfir_o  <= 1'b0;
      ctrl_upd_o <= 1'b0;
    end else begin
      tog_q_r    <= tog_s;
      ctrl_upd_o <= tog_s ^ tog_q_r;
      if (tog_s ^ tog_q_r) begin
        ctrl_o    <= regs_r;
        rx_sir_o  <= (regs_r.rx_mode == IRSC_RX_SIR);
        rx_vfir_o <= (regs_r.rx_mode == IRSC_RX_VFIR);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence s_write_body;
    (st_r == IRSC_S_SEP) ##1 (st_r == IRSC_S_DATA) [*8]
      ##1 (st_r == IRSC_S_STOP) [*2] ##1 (st_r == IRSC_S_HUNT0);
  endsequence

  sequence s_write_hdr;
    (st_r == IRSC_S_HDR) && (cnt_r == IRSC_HDR_LAST) && hdr_nxt[0] &&
    (hdr_nxt[4:1] != IRSC_IDX_RESET);
  endsequence

  property p_write_len;
    @(posedge sclk_i) disable iff (!rst_sync_b || idle)
      s_write_hdr |=> s_write_body;
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("write frame length wrong");

  property p_sync_order;
    @(posedge sclk_i) disable iff (!rst_sync_b)
      (st_r == IRSC_S_HUNT1) && wd && !idle |=> (st_r == IRSC_S_HDR);
  endproperty
  a_sync_order: assert property (p_sync_order)
    else $error("sync pattern not followed by header");

  property p_idle_reset;
    @(posedge sclk_i) disable iff (!rst_sync_b)
      idle |=> (st_r == IRSC_S_HUNT0) && (regs_r == IRSC_CTRL_RST);
  endproperty
  a_idle_reset: assert property (p_idle_reset)
    else $error("idle low did not reset");

  property p_special_reset;
    @(posedge sclk_i) disable iff (!rst_sync_b)
      rst_cmd |=> (regs_r == IRSC_CTRL_RST) && (st_r == IRSC_S_HUNT0);
  endproperty
  a_special_reset: assert property (p_special_reset)
    else $error("special reset ignored");

  property p_resp_own;
    @(posedge sclk_i) disable iff (!rst_sync_b)
      read_data_oe_o && !rx_oe_i |-> (addr == IRSC_OWN_ADDR) && !dir;
  endproperty
  a_resp_own: assert property (p_resp_own)
    else $error("response for foreign or broadcast read");

  property p_resp_len;
    @(posedge sclk_i) disable iff (!rst_sync_b || idle || rx_oe_i)
      $rose(read_data_oe_o) |-> read_data_oe_o [*8] ##1 !read_data_oe_o;
  endproperty
  a_resp_len: assert property (p_resp_len)
    else $error("response phase not eight bits");

  property p_escape_nowrite;
    @(posedge sclk_i) disable iff (!rst_sync_b)
      frame_end && (idx == IRSC_IDX_ESCAPE) && !idle |=> $stable(regs_r);
  endproperty
  a_escape_nowrite: assert property (p_escape_nowrite)
    else $error("escape index wrote a register");

  property p_foreign_ignored;
    @(posedge sclk_i) disable iff (!rst_sync_b)
      frame_end && !addr_hit(addr) && !idle |=> $stable(regs_r);
  endproperty
  a_foreign_ignored: assert property (p_foreign_ignored)
    else $error("foreign address changed a register");

  property p_mode_vfir;
    @(posedge clk_i) disable iff (!rst_sync_b)
      ctrl_upd_o |-> (rx_vfir_o == (ctrl_o.rx_mode == IRSC_RX_VFIR)) &&
                     (rx_sir_o == (ctrl_o.rx_mode == IRSC_RX_SIR));
  endproperty
  a_mode_vfir: assert property (p_mode_vfir)
    else $error("receive mode select mismatch");

endmodule : irsc_top

// [verif/irsc_ctl_model.sv]
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// interface controller model: serial clock and write data
// ---------------------------------------------------------------------------
module irsc_ctl_model (
  // bench side
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic [31:0] bits_i,
  input  wire logic [5:0]  len_i,
  input  wire logic        slow_i,
  output logic             done_o,
  output logic [3:0]       rbits_o,
  output logic [7:0]       rdata_o,
  // serial link
  input  wire logic        read_i,
  input  wire logic        read_oe_i,
  output logic             sclk_o,
  output logic             wd_o
);
  int hp;

  // idle levels; clock stands still low between frames
  initial begin
    done_o  = 1'b0;
    rbits_o = 4'h0;
    rdata_o = 8'h00;
    sclk_o  = 1'b0;
    wd_o    = 1'b0;
  end

  // one frame per start; writes use clock and data only
  always begin
    @(posedge clk_i);
    if (start_i === 1'b1) begin
      hp      = slow_i ? 400 : 16; // slow case is near static
      rbits_o = 4'h0;
      rdata_o = 8'h00;
      #3;
      for (int i = 0; i < len_i; i++) begin
        wd_o = bits_i[i]; // lsb first, set up half a period early
        #(hp);
        sclk_o = 1'b1;
        #(hp);
        sclk_o = 1'b0;
        // response bit stands a full period, so the fall is safe
        if (read_oe_i === 1'b1) begin
          rdata_o = {read_i, rdata_o[7:1]};
          rbits_o = rbits_o + 4'h1;
        end
      end
      done_o = 1'b1;
      @(posedge clk_i);
      @(negedge clk_i);
      done_o = 1'b0;
    end
  end
endmodule : irsc_ctl_model

// [verif/tb_ir_transceiver_serial_ctrl.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
// ---------------------------------------------------------------------------
// bench top
// ---------------------------------------------------------------------------
module tb_ir_transceiver_serial_ctrl;
  import irsc_pkg::*;
  logic        clk_i, rst_b_i, rx_data_i, rx_oe_i, start, slow, tick;
  logic        sclk, wd, rd_line, rd_oe, upd, sir, vfir, done;
  logic [31:0] bits;
  logic [5:0]  len;
  logic [3:0]  rbits;
  logic [7:0]  rdata, d;
  logic [25:0] en;
  logic [11:0] er;
  irsc_ctrl_t  ctrl, ec;
  logic [25:0] exp_q[$];
  logic [11:0] rd_q[$];
  int          num_errors, compares, upd_cnt, seed;

  irsc_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
    .write_data_pin_i(wd), .read_data_o(rd_line), .read_data_oe_o(rd_oe),
    .rx_data_i(rx_data_i), .rx_oe_i(rx_oe_i), .ctrl_o(ctrl),
    .rx_sir_o(sir), .rx_vfir_o(vfir), .ctrl_upd_o(upd));
  irsc_ctl_model ctl_u (.clk_i(clk_i), .start_i(start), .bits_i(bits),
    .len_i(len), .slow_i(slow), .done_o(done), .rbits_o(rbits),
    .rdata_o(rdata), .read_i(rd_line), .read_oe_i(rd_oe), .sclk_o(sclk),
    .wd_o(wd));

  // 50 MHz system clock
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  // ---------------------------------------------------------------------------
  // frame builders, fields lsb first
  // ---------------------------------------------------------------------------
  function automatic logic [9:0] hdr(logic c, logic [3:0] i, logic [2:0] a);
    return {a, i, c, IRSC_SYNC_SECOND, IRSC_SYNC_FIRST};
  endfunction : hdr
  function automatic logic [31:0] wr(logic [3:0] i, logic [2:0] a,
                                     logic [7:0] v, logic [1:0] st);
    return {11'h000, st, v, 1'b1, hdr(IRSC_DIR_WRITE, i, a)};
  endfunction : wr
  // ready bit low, then high through the response
  function automatic logic [31:0] rdf(logic [3:0] i, logic [2:0] a);
    return {13'h0000, 8'hFF, 1'b0, hdr(~IRSC_DIR_WRITE, i, a)};
  endfunction : rdf

  // ---------------------------------------------------------------------------
  // driver: notes expectations, then runs one frame
  // ---------------------------------------------------------------------------
  task frame(input logic [31:0] b, input int n, input logic [11:0] erd,
             input logic s);
    int k;
    rd_q.push_back(erd);
    exp_q.push_back({ec, ec.rx_mode === IRSC_RX_SIR,
                     ec.rx_mode === IRSC_RX_VFIR});
    @(posedge clk_i);
    bits  <= b;
    len   <= n[5:0];
    slow  <= s;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      @(posedge clk_i);
      k++;
    end
    // a frame that never finishes is a failure, not a silent skip
    if (k >= 5000) num_errors++;
    // crossing lands on the third clock edge after the last bit
    repeat (8) @(posedge clk_i);
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
  endtask : frame

  // receiver passthrough while no response runs
  task pass_chk();
    @(posedge clk_i);
    rx_oe_i <= 1'b1;
    repeat (6) begin
      @(negedge clk_i);
      `CHK({rd_oe, rd_line}, {1'b1, rx_data_i})
    end
    @(posedge clk_i);
    rx_oe_i <= 1'b0;
  endtask : pass_chk

  task report_and_stop();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------------------
  // monitor: oldest note against each result
  // ---------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (upd === 1'b1) upd_cnt++;
    if (done === 1'b1) begin
      er = rd_q.pop_front();
      `CHK({rbits, rdata}, er)
    end
    if (tick === 1'b1) begin
      en = exp_q.pop_front();
      `CHK({ctrl, sir, vfir}, en)
    end
  end

  // random receiver data keeps the passthrough honest
  always @(posedge clk_i) rx_data_i <= 1'($random(seed));

  // watchdog well beyond the expected run
  initial begin
    #400_000;
    num_errors++;
    report_and_stop();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 91929;
    {num_errors, compares, upd_cnt} = '0;
    {start, slow, tick, rx_oe_i, rx_data_i, rst_b_i} = '0;
    bits = 32'h0000_0000;
    len  = 6'h00;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    ec = IRSC_CTRL_RST;
    ec.rx_mode = IRSC_RX_VFIR;
    frame(wr(IRSC_IDX_RXMODE, IRSC_OWN_ADDR, IRSC_RX_VFIR, 2'b00), 21, 0, 0);
    `CHK(upd_cnt, 1)
    frame(rdf(IRSC_IDX_RXMODE, IRSC_OWN_ADDR), 19, {4'h8, IRSC_RX_VFIR}, 0);
    // each basic register, rx mode written by broadcast address, the others by own
    for (int r = 0; r < 3; r++) begin
      d = 8'($random(seed));
      ec[8*(2-r) +: 8] = d;
      frame(wr(r[3:0], r[0] ? IRSC_BCAST_ADDR : IRSC_OWN_ADDR, d, 2'b00),
            21, 0, 0);
      frame(rdf(r[3:0], IRSC_OWN_ADDR), 19, {4'h8, d}, 0);
    end
    frame(rdf(IRSC_IDX_COMMON, IRSC_BCAST_ADDR), 19, 0, 0);
    // foreign addresses are followed but change nothing
    for (int a = 0; a < 7; a++)
      if (a != 2) frame(wr(IRSC_IDX_RXMODE, a[2:0], 8'h03, 2'b00), 21, 0, 0);
    frame(wr(IRSC_IDX_ESCAPE, IRSC_OWN_ADDR, 8'h05, 2'b00), 21, 0, 0);
    frame(wr(4'h5, IRSC_OWN_ADDR, 8'h05, 2'b00), 21, 0, 0);
    frame(wr(IRSC_IDX_RXMODE, IRSC_OWN_ADDR, 8'h05, 2'b01), 21, 0, 0);
    d = 8'($random(seed));
    ec.led = d;
    frame(wr(IRSC_IDX_LED, IRSC_OWN_ADDR, d, 2'b00), 21, 0, 0);
    // extended read framed silently, next frame still decoded
    frame({2'b00, 8'hFF, 4'hE, 8'h01,
           hdr(~IRSC_DIR_WRITE, IRSC_IDX_ESCAPE, IRSC_OWN_ADDR)}, 30, 0, 0);
    frame(rdf(IRSC_IDX_LED, IRSC_OWN_ADDR), 19, {4'h8, d}, 0);
    d = 8'($random(seed));
    ec.common = d;
    frame(wr(IRSC_IDX_COMMON, IRSC_BCAST_ADDR, d, 2'b00), 21, 0, 1);
    ec = IRSC_CTRL_RST;
    frame({22'h00_0000, hdr(IRSC_DIR_WRITE, IRSC_IDX_RESET, IRSC_OWN_ADDR)},
          12, 0, 0);
    // data 05 ends in five lows: tail 5 + stops 2 + run 21 + sync 1 = 29
    // lows keep state; stops 2 + run 28 reach 30 and restore defaults
    ec.rx_mode = IRSC_RX_VFIR;
    frame(wr(IRSC_IDX_RXMODE, IRSC_OWN_ADDR, IRSC_RX_VFIR, 2'b00), 21, 0, 0);
    frame(32'h0000_0000, 21, 0, 0);
    d = 8'($random(seed));
    ec.led = d;
    frame(wr(IRSC_IDX_LED, IRSC_OWN_ADDR, d, 2'b00), 21, 0, 0);
    ec = IRSC_CTRL_RST;
    frame(32'h0000_0000, 28, 0, 0);
    frame(rdf(IRSC_IDX_RXMODE, IRSC_OWN_ADDR), 19, {4'h8, IRSC_RX_SIR}, 0);
    pass_chk();
    report_and_stop();
  end
endmodule : tb_ir_transceiver_serial_ctrl
